// [include/bfhs_pkg.sv]
// Purpose: Constants and carrier types for the buck fault hiccup sequencer
// Assumes: 10 MHz internal clock
// Notes:   Comparator results arrive as one packed struct
package bfhs_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned UV_DELAY_NS   = 30_000;
  localparam int unsigned UV_DELAY_CYC  =
    (UV_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned HICCUP_LIMIT  = 3;
  localparam int unsigned POR_LIMIT     = 3;
  localparam int unsigned CNT_W         = 2;

  // Comparator results, all from outside the clock domain
  typedef struct packed {
    logic feedback_low;   // Feedback below 75 % of target
    logic ss_above_4v;    // Soft-start level above 4 V
    logic ss_at_zero;     // Soft-start level at 0 V
    logic sense_ok;       // Supply sense above 1.5 V
    logic rail_12v_ok;    // 12 V supply ready
    logic internal_logic_rail_ok;
    logic enable;
  } bfhs_cmp_t;

  typedef enum logic [2:0] {
    BFHS_OFF      = 3'b000,
    BFHS_SOFT     = 3'b001,
    BFHS_RUN      = 3'b010,
    BFHS_HICCUP   = 3'b011,
    BFHS_SHUTDOWN = 3'b100
  } bfhs_state_t;

endpackage

// [rtl/bfhs_sequencer.sv]
// Purpose: Fault-protection sequencer of a synchronous buck controller
// Assumes: rst is the supply (VCC) power-up reset; comparators are asynchronous
// Notes:   Gate outputs are permits for the external drivers, not PWM
//
// Summary of operation
// - Undervoltage armed only while enabled and soft-start above 4 V.
// - Armed, feedback low continuously for 30 us starts a hiccup.
// - Hiccup first forces high-side and low-side drives off.
// - Hiccup enables the 10 uA soft-start discharge sink.
// - Soft-start at 0 V ends hiccup, stops discharge, restarts soft start.
// - Above 4 V after restart protection re-arms; persistent short hiccups again.
// - After 2 hiccups the third trip shuts down permanently, gates off, until supply cycled.
// - Power-on event or enable transition clears the hiccup counter.
// - Count power-on events including the first; third triggers short latch.
// - Short-circuit latch holds with gates off until supply removal.
// - Power-on only when logic rail, 12 V and enable all ready.
// - After power-on, start soft start with the 10 uA charge source.
// - Input supply ready only when sense exceeds 1.5 V.
// - Enable low inhibits all gate drive.
module bfhs_sequencer
  import bfhs_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire bfhs_cmp_t cmp_in,
  output logic           high_side_drive,
  output logic           low_side_drive,
  output logic           ss_charge_en,
  output logic           ss_discharge_en,
  output logic           undervoltage_trip,
  output logic           short_circuit_latch,
  output logic           shutdown_latched
);

  localparam int unsigned UV_W = $clog2(UV_DELAY_CYC + 1);

  // Counters saturate one below their limit, so each limit must fit the width
  if (HICCUP_LIMIT < 1 || HICCUP_LIMIT > (1 << CNT_W)
      || POR_LIMIT < 1 || POR_LIMIT > (1 << CNT_W))
    $error("Event limit does not fit counter width");

  // ******************************
  // Input synchronisers
  // ******************************
  bfhs_cmp_t sync1;
  bfhs_cmp_t cmp;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= '0;
      cmp   <= '0;
    end
    else
    begin
      sync1 <= cmp_in;
      cmp   <= sync1;
    end
  end

  // ******************************
  // Decode
  // ******************************
  bfhs_state_t state;
  bfhs_state_t next_state;
  logic              por_prev;
  logic              en_prev;
  logic [CNT_W-1:0]  hiccup_cnt;
  logic [CNT_W-1:0]  por_cnt;
  logic [UV_W-1:0]   uv_cnt;

  wire por_ok    = cmp.internal_logic_rail_ok & cmp.rail_12v_ok
                 & cmp.sense_ok & cmp.enable;
  wire por_event = por_ok & ~por_prev;
  wire en_toggle = cmp.enable ^ en_prev;
  wire armed     = cmp.enable & cmp.ss_above_4v & (state == BFHS_RUN);
  wire uv_fire   = armed & cmp.feedback_low
                 & (uv_cnt == UV_W'(UV_DELAY_CYC - 1));
  wire hiccup_full = (hiccup_cnt == CNT_W'(HICCUP_LIMIT - 1));
  wire scp_fire    = por_event & (por_cnt == CNT_W'(POR_LIMIT - 1));
  wire gates_on    = (next_state == BFHS_RUN) | (next_state == BFHS_SOFT);

  always_comb
  begin
    next_state = state;
    unique case (state)
      BFHS_OFF:
        if (por_event)
          next_state = BFHS_SOFT;
      BFHS_SOFT:
        if (cmp.ss_above_4v)
          next_state = BFHS_RUN;
      BFHS_RUN:
        if (uv_fire)
          next_state = hiccup_full ? BFHS_SHUTDOWN : BFHS_HICCUP;
      BFHS_HICCUP:
        if (cmp.ss_at_zero)
          next_state = BFHS_SOFT;
      BFHS_SHUTDOWN:
        next_state = BFHS_SHUTDOWN;
      default:
        next_state = BFHS_OFF;
    endcase
    if (state != BFHS_SHUTDOWN)
    begin
      // Hiccup keeps discharging without power-on, but never restarts soft start
      if (!por_ok && (state != BFHS_HICCUP || cmp.ss_at_zero))
        next_state = BFHS_OFF;
      if (short_circuit_latch || scp_fire)
        next_state = BFHS_SHUTDOWN;
    end
  end

  // ******************************
  // Sequencer state
  // ******************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state    <= BFHS_OFF;
      por_prev <= 1'b0;
      en_prev  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      por_prev <= por_ok;
      en_prev  <= cmp.enable;
    end
  end

  // Qualification timer restarts on any high feedback sample
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      uv_cnt <= '0;
    else if (!(armed && cmp.feedback_low) || uv_fire)
      uv_cnt <= '0;
    else
      uv_cnt <= uv_cnt + UV_W'(1);
  end

  // ******************************
  // Event counters
  // ******************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      hiccup_cnt <= '0;
    else if (por_event || en_toggle)
      hiccup_cnt <= '0;
    else if (uv_fire && !hiccup_full)
      hiccup_cnt <= hiccup_cnt + CNT_W'(1);
  end

  // Only supply removal clears this; enable bounces add counts
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      por_cnt <= '0;
    else if (por_event && por_cnt != CNT_W'(POR_LIMIT - 1))
      por_cnt <= por_cnt + CNT_W'(1);
  end

  // ******************************
  // Outputs
  // ******************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      high_side_drive     <= 1'b0;
      low_side_drive      <= 1'b0;
      ss_charge_en        <= 1'b0;
      ss_discharge_en     <= 1'b0;
      undervoltage_trip   <= 1'b0;
      short_circuit_latch <= 1'b0;
      shutdown_latched    <= 1'b0;
    end
    else
    begin
      high_side_drive     <= gates_on;
      low_side_drive      <= gates_on;
      ss_charge_en        <= (next_state == BFHS_SOFT) | (next_state == BFHS_RUN);
      ss_discharge_en     <= (next_state == BFHS_HICCUP);
      undervoltage_trip   <= uv_fire;
      short_circuit_latch <= short_circuit_latch | scp_fire;
      shutdown_latched    <= (next_state == BFHS_SHUTDOWN);
    end
  end

  // ******************************
  // Assertions
  // ******************************
  a_hiccup_gates_off: assert property (@(posedge mclk) disable iff (rst)
    ss_discharge_en |-> !high_side_drive && !low_side_drive)
    else $error("Gates on during hiccup");

  a_uv_starts_hiccup: assert property (@(posedge mclk) disable iff (rst)
    uv_fire && !hiccup_full && !scp_fire && por_ok |=> ss_discharge_en)
    else $error("Undervoltage did not start hiccup");

  a_uv_needs_arm: assert property (@(posedge mclk) disable iff (rst)
    !cmp.ss_above_4v |=> !undervoltage_trip)
    else $error("Undervoltage tripped while unarmed");

  a_hiccup_ends_zero: assert property (@(posedge mclk) disable iff (rst)
    state == BFHS_HICCUP && cmp.ss_at_zero && !short_circuit_latch && !scp_fire
      |=> !ss_discharge_en && ss_charge_en == por_ok)
    else $error("Hiccup did not end at zero");

  a_scp_holds: assert property (@(posedge mclk) disable iff (rst)
    short_circuit_latch |=> short_circuit_latch && !high_side_drive)
    else $error("Short latch released");

  a_enable_inhibit: assert property (@(posedge mclk) disable iff (rst)
    !cmp.enable |=> !high_side_drive && !low_side_drive)
    else $error("Drive while disabled");

  a_shutdown_sticky: assert property (@(posedge mclk) disable iff (rst)
    shutdown_latched |=> shutdown_latched && !low_side_drive)
    else $error("Shutdown released");

  a_por_charge: assert property (@(posedge mclk) disable iff (rst)
    state == BFHS_OFF && por_event && !scp_fire |=> ss_charge_en)
    else $error("No soft start after power-on");

  a_counter_clear: assert property (@(posedge mclk) disable iff (rst)
    en_toggle |=> hiccup_cnt == '0)
    else $error("Hiccup count not cleared");

endmodule

// [test/bfhs_ss_model.sv]
// Purpose: Soft-start capacitor and comparators beside the sequencer
// Assumes: One level step per clock, far quicker than a real ramp
// Notes:   Cap is pulled to ground when neither source nor sink runs
module bfhs_ss_model
#(
  parameter int unsigned SS_TOP = 50
)
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic charge_en,
  input  wire logic discharge_en,
  output logic      ss_above_4v,
  output logic      ss_at_zero
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned level;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      level <= 0;
    else if (charge_en)
      level <= (level < SS_TOP) ? level + 1 : level;
    else if (discharge_en)
      level <= (level > 0) ? level - 1 : 0;
    else
      level <= 0;
  assign ss_above_4v = level > SS_TOP * 4 / 5;
  assign ss_at_zero  = level == 0;
endmodule

// [test/tb.sv]
// Purpose: Self-checking bench of the hiccup sequencer
// Assumes: Soft-start model ramps in tens of cycles
// Notes:   Enable edges are clean; each rise is a power-on event
module tb
  import bfhs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0b got %0b", nm, e, g); end end
  logic            mclk;
  logic            rst;
  logic            fb_low;
  logic            en;
  logic            sense;
  wire logic       ss_hi, ss_zero, hs, ls, chg, dis, uv, scl, sdl;
  wire logic [4:0] obs = {ss_hi, scl, sdl, chg, dis};
  int              error_cnt = 0;
  int              total_checks = 0;
  bfhs_cmp_t       cmp;
  // Both rails tied ready: sense and enable carry the power-on tests
  assign cmp = '{fb_low, ss_hi, ss_zero, sense, 1'b1, 1'b1, en};
  bfhs_sequencer dut (.mclk(mclk), .rst(rst), .cmp_in(cmp), .high_side_drive(hs),
    .low_side_drive(ls), .ss_charge_en(chg), .ss_discharge_en(dis),
    .undervoltage_trip(uv), .short_circuit_latch(scl), .shutdown_latched(sdl));
  bfhs_ss_model ss (.mclk(mclk), .rst(rst), .charge_en(chg), .discharge_en(dis),
    .ss_above_4v(ss_hi), .ss_at_zero(ss_zero));
  // ****************
  // Helpers
  // ****************
  function automatic logic trips(int n);
    return n >= UV_DELAY_CYC;
  endfunction
  task automatic await(int w, string nm);
    for (int i = 0; i < 1000 && obs[w] !== 1'b1; i++)
    begin
      @(posedge mclk);
      #1;
    end
    `CHK(nm, 1'b1, obs[w])
  endtask
  task automatic hiccup(logic last);
    await(4, "run");
    @(posedge mclk) fb_low <= 1'b1;
    await(last ? 2 : 0, "trip");
    `CHK("hs_off", 1'b0, hs)
    `CHK("ls_off", 1'b0, ls)
    if (!last)
    begin
      `CHK("uv", 1'b1, uv)
      `CHK("chg_off", 1'b0, chg)
    end
    @(posedge mclk) fb_low <= 1'b0;
    if (!last)
    begin
      await(1, "restart");
      `CHK("dis_off", 1'b0, dis)
      `CHK("hs_back", 1'b1, hs)
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ****************
  // Clock, watchdog, tests
  // ****************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
  initial
  begin
    int n;
    void'($urandom(92165));
    rst = 1'b1;
    {fb_low, en, sense} = 3'h2;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (20) @(posedge mclk);
    #1 `CHK("no_sense", 1'b0, chg)
    @(posedge mclk) sense <= 1'b1;
    await(1, "por");
    `CHK("hs_on", 1'b1, hs)
    await(4, "run_1");
    // Short dips below the count must never trip
    for (int i = 0; i < 20; i++)
    begin
      n = (i == 19) ? UV_DELAY_CYC - 1 : $urandom_range(UV_DELAY_CYC - 10, 1);
      @(posedge mclk) fb_low <= 1'b1;
      repeat (n) @(posedge mclk);
      fb_low <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 `CHK("glitch", trips(n), dis)
    end
    hiccup(0);
    hiccup(0);
    @(posedge mclk) en <= 1'b0;
    repeat (5) @(posedge mclk);
    #1 `CHK("en_low", 1'b0, hs)
    @(posedge mclk) en <= 1'b1;
    await(1, "re_en");
    hiccup(0);
    hiccup(0);
    hiccup(1);
    repeat (60) @(posedge mclk);
    #1 `CHK("shut", 1'b0, hs)
    @(posedge mclk) rst <= 1'b1;
    @(posedge mclk) rst <= 1'b0;
    #1 `CHK("sd_clr", 1'b0, sdl)
    await(1, "por_1");
    // Enable lost mid-hiccup: discharge runs out, no soft start follows
    await(4, "run_2");
    @(posedge mclk) fb_low <= 1'b1;
    await(0, "trip_2");
    @(posedge mclk) {fb_low, en} <= 2'b00;
    for (int i = 0; i < 80; i++)
    begin
      @(posedge mclk);
      #1 `CHK("off_chg", 1'b0, chg)
    end
    `CHK("off_dis", 1'b0, dis)
    for (int k = 0; k < 3; k++)
    begin
      @(posedge mclk) en <= 1'b0;
      repeat (5) @(posedge mclk);
      en <= 1'b1;
      repeat (5) @(posedge mclk);
      if (k == 1)
        await(3, "scp");
      else if (k == 0)
        #1 `CHK("scp_early", 1'b0, scl)
    end
    #1 `CHK("scp_hold", 1'b1, scl)
    `CHK("scp_hs", 1'b0, hs)
    results();
  end
endmodule
